/* File: hw/imh_pkg.sv */
package imh_pkg;
   localparam int DATA_W = 16;
   localparam int IDX_W  = 8;
   localparam int PTR_W  = 17;
   localparam int MEM_AW = 10;
   localparam logic [7:0] IDX_PTR_LOW   = 8'hC0;
   localparam logic [7:0] IDX_PTR_MID   = 8'hC1;
   localparam logic [7:0] IDX_PTR_TOP   = 8'hC2;
   localparam logic [7:0] IDX_BURST     = 8'hC4;
   localparam logic [7:0] IDX_WORD_ONLY = 8'hC6;
   localparam int WORD_ONLY_BIT = 0;
   localparam int PTR_TOP_BIT   = 16;
   localparam logic [PTR_W-1:0] PTR_STEP_BYTE = 17'h00001;
   localparam logic [PTR_W-1:0] PTR_STEP_WORD = 17'h00002;
   localparam int NUM_REGS = 256;
   // host strobe hold, in sys_clk cycles; covers the device's two-flop sync plus one
   localparam int STROBE_CYCLES = 4;
   localparam int GAP_CYCLES    = 4;
   // host command register offsets (wishbone byte addresses)
   localparam logic [3:0] WB_CTRL   = 4'h0;
   localparam logic [3:0] WB_DATA   = 4'h4;
   localparam logic [3:0] WB_STATUS = 4'h8;
   localparam logic [3:0] WB_RDATA  = 4'hC;
   // control field positions
   localparam int CTRL_GO     = 0;
   localparam int CTRL_CMD    = 1;
   localparam int CTRL_READ   = 2;
   localparam int CTRL_UPPER  = 3;
   localparam int CTRL_LOWER  = 4;
   localparam int CTRL_STYLE  = 5;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_GAP
   } imh_state_type;
endpackage

/* File: hw/imh_bus_if.sv */
`timescale 1ns/1ps
interface imh_bus_if;
   import imh_pkg::*;
   logic              busStyleSelectN;
   logic              cmdSelect;
   logic              upperWriteStrobeN;
   logic              lowerWriteStrobeN;
   logic              upperReadStrobeN;
   logic              lowerReadStrobeN;
   logic              upperByteEnable;
   logic              lowerByteEnable;
   logic              rwSelect;
   logic [DATA_W-1:0] hostData;
   logic              hostDataOe;
   logic [DATA_W-1:0] devData;
   logic              devDataOe;
   modport device (
      input  busStyleSelectN, cmdSelect, upperWriteStrobeN, lowerWriteStrobeN,
      input  upperReadStrobeN, lowerReadStrobeN, upperByteEnable, lowerByteEnable,
      input  rwSelect, hostData, hostDataOe,
      output devData, devDataOe
   );
   modport host (
      output busStyleSelectN, cmdSelect, upperWriteStrobeN, lowerWriteStrobeN,
      output upperReadStrobeN, lowerReadStrobeN, upperByteEnable, lowerByteEnable,
      output rwSelect, hostData, hostDataOe,
      input  devData, devDataOe
   );
endinterface

/* File: hw/imh_device.sv */
// Summary of operation
// - two strobe styles chosen by style pin
// - byte and word transfers, either byte order
// - command write sets index, data moves value
// - 17-bit pointer in registers C0h to C2h
// - word-only bit forces words, ignores upper strobes
// - otherwise strobes set access width
// - enable style, even byte on upper lane
// - enable style, odd byte on either lane
// - enable style word: even upper, odd lower
// - word write to C0h loads pointer 15..0
// - C2h bit 0 is pointer bit 16
// - command to C4h arms burst memory access
// - byte burst access adds one
// - word burst access adds two
// - byte order matters for memory words only
// - host keeps pointer even in word-only mode
// - register access always honours upper enable
// - host sets pointer then starts burst
// - word-only burst may start with C4h alone
// - strobe style: command low byte, even low
`timescale 1ns/1ps
module imh_device
   import imh_pkg::*;
#(
   parameter int MEM_ADDR_W = MEM_AW
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic clkEn,
   // byte order of memory words: 1 = big
   input  wire logic bigEndian,
   // link
   imh_bus_if.device bus,
   // status
   output logic [PTR_W-1:0] memPointer,
   output logic             burstActive
);
   // pins cross from the host: two flops before any logic reads them
   localparam int SW = 9 + DATA_W;
   logic [SW-1:0] syncA_r;
   logic [SW-1:0] syncB_r;
   logic [SW-1:0] prev_r;
   logic          styleN;
   logic          cmdSel;
   logic          wrU, wrL, rdU, rdL, upper_byte_enable, lower_byte_enable, rwSel;
   logic [DATA_W-1:0] din;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         syncA_r <= '0;
         syncB_r <= '0;
      end else if (clkEn) begin
         syncA_r <= {bus.busStyleSelectN, bus.cmdSelect, ~bus.upperWriteStrobeN,
                     ~bus.lowerWriteStrobeN, ~bus.upperReadStrobeN, ~bus.lowerReadStrobeN,
                     bus.upperByteEnable, bus.lowerByteEnable, bus.rwSelect, bus.hostData};
         syncB_r <= syncA_r;
      end
   end
   assign {styleN, cmdSel, wrU, wrL, rdU, rdL, upper_byte_enable, lower_byte_enable, rwSel, din} = syncB_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prev_r <= '0;
      end else if (clkEn) begin
         prev_r <= syncB_r;
      end
   end

   // style decode; styleN high = enable-strobe style, low = write/read strobes
   logic enStyle;
   logic upAct, loAct, isWrite, active, prevActive, startEv;
   assign enStyle = styleN;
   always_comb begin
      if (enStyle) begin
         upAct   = upper_byte_enable;
         loAct   = lower_byte_enable;
         isWrite = ~rwSel;
      end else begin
         upAct   = wrU | rdU;
         loAct   = wrL | rdL;
         isWrite = wrU | wrL;
      end
   end
   assign active     = upAct | loAct;
   // previous enables sit at DATA_W+2 (upper) and DATA_W+1 (lower), strobes at DATA_W+6 down to DATA_W+3;
   // the command pin must stay out of this, it stands between transfers
   assign prevActive = enStyle ? (prev_r[DATA_W+2] | prev_r[DATA_W+1])
                               : (|prev_r[DATA_W+6:DATA_W+3]);
   // act on the leading edge, data already stable two cycles
   assign startEv = active & ~prevActive;

   logic [IDX_W-1:0] index_r;
   logic [PTR_W-1:0] ptr_r;
   logic             wordOnly_r;
   logic             burst_r;
   logic [7:0]       regs_r [NUM_REGS];
   logic [7:0]       mem_r  [2**MEM_ADDR_W];
   logic [DATA_W-1:0] dout_r;
   logic              doe_r;

   // memory width: word-only ignores upper strobes
   logic memUp, memLo, memWord;
   assign memLo   = wordOnly_r ? loAct : loAct;
   assign memUp   = wordOnly_r ? loAct : upAct;
   assign memWord = memUp & memLo;

   // lane of a byte at address a; word uses byte order
   logic [MEM_ADDR_W-1:0] mA0, mA1;
   assign mA0 = ptr_r[MEM_ADDR_W-1:0];
   assign mA1 = mA0 + 1'b1;

   logic [7:0] evenReg, oddReg;
   logic [IDX_W-1:0] oddIdx;
   assign oddIdx = index_r | 8'h01;
   function automatic logic [7:0] rdReg(input logic [IDX_W-1:0] i, input logic [PTR_W-1:0] p,
                                        input logic w, input logic [7:0] v);
      case (i)
         IDX_PTR_LOW:   rdReg = p[7:0];
         IDX_PTR_MID:   rdReg = p[15:8];
         IDX_PTR_TOP:   rdReg = {7'h00, p[PTR_TOP_BIT]};
         IDX_BURST:     rdReg = 8'h00;
         IDX_WORD_ONLY: rdReg = {7'h00, w};
         default:       rdReg = v;
      endcase
   endfunction
   assign evenReg = rdReg(index_r & 8'hFE, ptr_r, wordOnly_r, regs_r[index_r & 8'hFE]);
   assign oddReg  = rdReg(oddIdx, ptr_r, wordOnly_r, regs_r[oddIdx]);

   // even byte lane: upper in enable style, lower in strobe style
   logic [7:0] evenIn, oddIn;
   logic       regWord;
   assign regWord = upAct & loAct;
   assign evenIn  = enStyle ? din[15:8] : din[7:0];
   // a lone odd byte rides whichever lane was strobed
   assign oddIn   = regWord ? (enStyle ? din[7:0] : din[15:8]) : (upAct ? din[15:8] : din[7:0]);

   // register side: index, pointer, word-only, spare storage
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         index_r    <= '0;
         ptr_r      <= '0;
         wordOnly_r <= 1'b0;
         burst_r    <= 1'b0;
      end else if (clkEn && startEv) begin
         if (cmdSel) begin
            if (isWrite) begin
               index_r <= din[IDX_W-1:0];
               burst_r <= (din[IDX_W-1:0] == IDX_BURST);
            end
         end else if (burst_r) begin
            ptr_r <= ptr_r + (memWord ? PTR_STEP_WORD : PTR_STEP_BYTE);
         end else if (isWrite) begin
            // byte to one register, word to even/odd pair
            if (regWord || (index_r[0] == 1'b0)) begin
               case (index_r & 8'hFE)
                  IDX_PTR_LOW: ptr_r[7:0] <= evenIn;
                  IDX_PTR_TOP: ptr_r[PTR_TOP_BIT] <= evenIn[0];
                  IDX_WORD_ONLY: wordOnly_r <= evenIn[WORD_ONLY_BIT];
                  default: ;
               endcase
            end
            if (regWord || index_r[0]) begin
               if (oddIdx == IDX_PTR_MID) begin
                  ptr_r[15:8] <= oddIn;
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clkEn && startEv && !cmdSel && isWrite) begin
         if (burst_r) begin
            if (memWord) begin
               mem_r[mA0] <= bigEndian ? din[15:8] : din[7:0];
               mem_r[mA1] <= bigEndian ? din[7:0] : din[15:8];
            end else begin
               mem_r[mA0] <= memUp ? din[15:8] : din[7:0];
            end
         end else begin
            if (regWord || !index_r[0]) regs_r[index_r & 8'hFE] <= evenIn;
            if (regWord || index_r[0])  regs_r[oddIdx] <= oddIn;
         end
      end
   end

   // read answer: presented while the read strobe stands
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dout_r <= '0;
         doe_r  <= 1'b0;
      end else if (clkEn) begin
         doe_r <= active & ~isWrite & ~cmdSel;
         if (startEv && !isWrite && !cmdSel) begin
            if (burst_r) begin
               if (memWord) begin
                  dout_r <= bigEndian ? {mem_r[mA0], mem_r[mA1]} : {mem_r[mA1], mem_r[mA0]};
               end else begin
                  dout_r <= {mem_r[mA0], mem_r[mA0]};
               end
            end else if (regWord) begin
               dout_r <= enStyle ? {evenReg, oddReg} : {oddReg, evenReg};
            end else begin
               dout_r <= index_r[0] ? {oddReg, oddReg} : {evenReg, evenReg};
            end
         end
      end
   end

   assign bus.devData   = dout_r;
   assign bus.devDataOe = doe_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         memPointer  <= '0;
         burstActive <= 1'b0;
      end else if (clkEn) begin
         memPointer  <= ptr_r;
         burstActive <= burst_r;
      end
   end
endmodule

/* File: hw/imh_host.sv */
`timescale 1ns/1ps
module imh_host
   import imh_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic clkEn,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // link
   imh_bus_if.host bus
);
   imh_state_type state_r;
   logic [5:0]        ctrl_r;
   logic [DATA_W-1:0] wdata_r;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] sync1_r, sync2_r;
   logic [2:0]        cnt_r;
   logic              busy;
   logic              goReq;
   assign busy  = (state_r != ST_IDLE);
   assign goReq = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (wb_adr_i == WB_CTRL) & wb_sel_i[0]
                  & wb_dat_i[CTRL_GO] & ~busy;

   // wishbone: ack one cycle after request, dropped the next
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         ctrl_r   <= '0;
         wdata_r  <= '0;
      end else if (clkEn) begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            if (wb_we_i && wb_adr_i == WB_CTRL && wb_sel_i[0] && !busy) ctrl_r <= wb_dat_i[5:0];
            if (wb_we_i && wb_adr_i == WB_DATA && wb_sel_i[0]) wdata_r[7:0] <= wb_dat_i[7:0];
            if (wb_we_i && wb_adr_i == WB_DATA && wb_sel_i[1]) wdata_r[15:8] <= wb_dat_i[15:8];
            case (wb_adr_i)
               WB_CTRL:   wb_dat_o <= {26'h0, ctrl_r};
               WB_DATA:   wb_dat_o <= {16'h0, wdata_r};
               WB_STATUS: wb_dat_o <= {31'h0, busy};
               WB_RDATA:  wb_dat_o <= {16'h0, rdata_r};
               default:   wb_dat_o <= '0;
            endcase
         end
      end
   end

   // read data from the device passes two flops
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else if (clkEn) begin
         sync1_r <= bus.devData;
         sync2_r <= sync1_r;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         cnt_r   <= '0;
         rdata_r <= '0;
      end else if (clkEn) begin
         case (state_r)
            ST_IDLE: begin
               if (goReq) begin
                  state_r <= ST_SETUP;
                  cnt_r   <= '0;
               end
            end
            ST_SETUP: begin
               state_r <= ST_STROBE;
               cnt_r   <= '0;
            end
            ST_STROBE: begin
               cnt_r <= cnt_r + 3'd1;
               if (cnt_r == 3'(STROBE_CYCLES - 1)) begin
                  state_r <= ST_GAP;
                  cnt_r   <= '0;
               end
            end
            ST_GAP: begin
               cnt_r <= cnt_r + 3'd1;
               // the device answers three cycles into the strobe and its data needs two more flops here,
               // so read data is taken only at the end of the gap
               if (cnt_r == 3'(GAP_CYCLES - 1)) begin
                  rdata_r <= sync2_r;
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // pin drive, straight from flops
   logic strobe, rd;
   assign strobe = (state_r == ST_STROBE);
   assign rd     = ctrl_r[CTRL_READ] & ~ctrl_r[CTRL_CMD];
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bus.busStyleSelectN   <= 1'b0;
         bus.cmdSelect         <= 1'b0;
         bus.upperWriteStrobeN <= 1'b1;
         bus.lowerWriteStrobeN <= 1'b1;
         bus.upperReadStrobeN  <= 1'b1;
         bus.lowerReadStrobeN  <= 1'b1;
         bus.upperByteEnable   <= 1'b0;
         bus.lowerByteEnable   <= 1'b0;
         bus.rwSelect          <= 1'b0;
         bus.hostData          <= '0;
         bus.hostDataOe        <= 1'b0;
      end else if (clkEn) begin
         bus.busStyleSelectN   <= ctrl_r[CTRL_STYLE];
         bus.cmdSelect         <= ctrl_r[CTRL_CMD];
         bus.rwSelect          <= rd;
         // command index always on the low lane
         bus.hostData          <= ctrl_r[CTRL_CMD] ? {8'h00, wdata_r[7:0]} : wdata_r;
         bus.hostDataOe        <= busy & ~rd;
         bus.upperWriteStrobeN <= ~(strobe & ~ctrl_r[CTRL_STYLE] & ~rd & ctrl_r[CTRL_UPPER]);
         bus.lowerWriteStrobeN <= ~(strobe & ~ctrl_r[CTRL_STYLE] & ~rd & (ctrl_r[CTRL_LOWER] | ctrl_r[CTRL_CMD]));
         bus.upperReadStrobeN  <= ~(strobe & ~ctrl_r[CTRL_STYLE] & rd & ctrl_r[CTRL_UPPER]);
         bus.lowerReadStrobeN  <= ~(strobe & ~ctrl_r[CTRL_STYLE] & rd & ctrl_r[CTRL_LOWER]);
         bus.upperByteEnable   <= strobe & ctrl_r[CTRL_STYLE] & ctrl_r[CTRL_UPPER];
         bus.lowerByteEnable   <= strobe & ctrl_r[CTRL_STYLE] & (ctrl_r[CTRL_LOWER] | ctrl_r[CTRL_CMD]);
      end
   end
endmodule

/* File: sim/imh_bus_properties.sv */
`timescale 1ns/1ps
module imh_bus_properties
   import imh_pkg::*;
(
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              rst,
   // link
   input wire logic              busStyleSelectN,
   input wire logic              cmdSelect,
   input wire logic              upperWriteStrobeN,
   input wire logic              lowerWriteStrobeN,
   input wire logic              upperReadStrobeN,
   input wire logic              lowerReadStrobeN,
   input wire logic              upperByteEnable,
   input wire logic              lowerByteEnable,
   input wire logic              rwSelect,
   input wire logic [DATA_W-1:0] hostData,
   input wire logic              hostDataOe,
   input wire logic [DATA_W-1:0] devData,
   input wire logic              devDataOe
);
   logic wrAct;
   logic rdAct;
   logic act;
   // the style pin decides which pins mean a transfer; idle pins of the other style are not trusted
   assign wrAct = busStyleSelectN ? ((upperByteEnable | lowerByteEnable) & ~rwSelect)
                                  : (~upperWriteStrobeN | ~lowerWriteStrobeN);
   assign rdAct = busStyleSelectN ? ((upperByteEnable | lowerByteEnable) & rwSelect)
                                  : (~upperReadStrobeN | ~lowerReadStrobeN);
   assign act   = wrAct | rdAct;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   strobe_length_a: assert property ($rose(act) |-> act [*4] ##1 !act)
      else $error("strobe not held four cycles");
   strobe_gap_a: assert property ($fell(act) |-> !act [*4])
      else $error("gap between strobes too short");
   style_hold_a: assert property (act && $past(act) |-> $stable(busStyleSelectN) && $stable(cmdSelect))
      else $error("style or command pin moved in a strobe");
   write_data_hold_a: assert property (wrAct && $past(wrAct) |-> $stable(hostData))
      else $error("host data moved in a write");
   host_drives_a: assert property (wrAct |-> hostDataOe)
      else $error("host not driving in a write");
   host_releases_a: assert property (rdAct |-> !hostDataOe)
      else $error("host driving in a read");
   command_write_a: assert property (cmdSelect && act |-> wrAct)
      else $error("command transfer is not a write");
   device_quiet_a: assert property (wrAct |-> !devDataOe)
      else $error("device drives during a write");
   device_answers_a: assert property ($rose(rdAct) |-> ##[1:5] devDataOe)
      else $error("device gave no read data");
   device_cause_a: assert property ($rose(devDataOe) |-> rdAct || $past(rdAct))
      else $error("device drove without a read");
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench
   import imh_pkg::*;
;
   logic        sys_clk   = 1'b0;
   logic        rst       = 1'b1;
   logic        bigEndian = 1'b0;
   logic        cyc       = 1'b0;
   logic        stb       = 1'b0;
   logic        we        = 1'b0;
   logic        rdChk     = 1'b0;
   logic [3:0]  adr       = 4'h0;
   logic [3:0]  sel       = 4'h0;
   logic [31:0] dat       = 32'h0;
   logic [31:0] datO;
   logic        ack;
   logic [16:0] memPtr;
   logic        burst;
   logic [31:0] rdLast;
   logic [31:0] e;
   logic [31:0] rv;
   logic [15:0] a;
   logic [7:0]  b;
   logic [7:0]  c;
   logic [31:0] expQ[$];
   integer      seed      = 32'h7FC30A65;
   integer      num_errors = 0;
   integer      num_checks = 0;
   always #2.5 sys_clk = ~sys_clk;
   imh_bus_if i_imh_bus_if ();
   imh_host i_imh_host (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
      .bus(i_imh_bus_if));
   imh_device i_imh_device (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .bigEndian(bigEndian),
      .bus(i_imh_bus_if), .memPointer(memPtr), .burstActive(burst));
   imh_bus_properties i_imh_bus_properties (.sys_clk(sys_clk), .rst(rst),
      .busStyleSelectN(i_imh_bus_if.busStyleSelectN), .cmdSelect(i_imh_bus_if.cmdSelect),
      .upperWriteStrobeN(i_imh_bus_if.upperWriteStrobeN), .lowerWriteStrobeN(i_imh_bus_if.lowerWriteStrobeN),
      .upperReadStrobeN(i_imh_bus_if.upperReadStrobeN), .lowerReadStrobeN(i_imh_bus_if.lowerReadStrobeN),
      .upperByteEnable(i_imh_bus_if.upperByteEnable), .lowerByteEnable(i_imh_bus_if.lowerByteEnable),
      .rwSelect(i_imh_bus_if.rwSelect), .hostData(i_imh_bus_if.hostData), .hostDataOe(i_imh_bus_if.hostDataOe),
      .devData(i_imh_bus_if.devData), .devDataOe(i_imh_bus_if.devDataOe));
   task automatic test_done();
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] x);
      num_checks++;
      if (seen !== x) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, x);
      end
   endtask
   // ack is sampled at the edge itself, before the slave's own update lands
   task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d, input logic ck);
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= ad;
      dat <= d;
      rdChk <= ck;
      @(posedge sys_clk iff ack === 1'b1);
      rdLast = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
      rdChk <= 1'b0;
   endtask
   task automatic op(input logic s, cm, r, u, l, input logic [15:0] d);
      logic [31:0] ctl;
      ctl = (32'h1 << CTRL_GO) | (32'(cm) << CTRL_CMD) | (32'(r) << CTRL_READ) | (32'(u) << CTRL_UPPER)
          | (32'(l) << CTRL_LOWER) | (32'(s) << CTRL_STYLE);
      wb(1'b1, WB_DATA, {16'h0, d}, 1'b0);
      wb(1'b1, WB_CTRL, ctl, 1'b0);
      do wb(1'b0, WB_STATUS, 32'h0, 1'b0); while (rdLast[0] !== 1'b0);
   endtask
   task automatic cmd(input logic s, input logic [7:0] i);
      op(s, 1'b1, 1'b0, 1'b0, 1'b1, {8'h00, i});
   endtask
   task automatic rdx(input logic s, u, l, input logic [15:0] m, input logic [15:0] x);
      op(s, 1'b0, 1'b1, u, l, 16'h0);
      expQ.push_back({m, x});
      wb(1'b0, WB_RDATA, 32'h0, 1'b1);
   endtask
   task automatic setp(input logic [16:0] p);
      cmd(1'b0, IDX_PTR_LOW);
      op(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, p[15:0]);
      cmd(1'b0, IDX_PTR_TOP);
      op(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, {15'h0, p[16]});
      cmd(1'b0, IDX_BURST);
   endtask
   always @(posedge sys_clk) begin
      if (ack === 1'b1 && rdChk === 1'b1) begin
         e = expQ.pop_front();
         chk({16'h0, datO[15:0] & e[31:16]}, {16'h0, e[15:0]});
      end
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      rv = $random(seed);
      a = rv[15:0];
      b = rv[23:16];
      c = rv[31:24];
      cmd(1'b0, IDX_PTR_LOW);
      op(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, a);
      chk({16'h0, memPtr[15:0]}, {16'h0, a});
      rdx(1'b0, 1'b1, 1'b1, 16'hFFFF, a);
      cmd(1'b1, IDX_PTR_LOW);
      op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, {b, 8'h00});
      chk({24'h0, memPtr[7:0]}, {24'h0, b});
      rdx(1'b1, 1'b1, 1'b0, 16'hFF00, {b, 8'h00});
      cmd(1'b1, IDX_PTR_MID);
      op(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, {8'h00, c});
      chk({24'h0, memPtr[15:8]}, {24'h0, c});
      op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, {b, 8'h00});
      chk({24'h0, memPtr[15:8]}, {24'h0, b});
      cmd(1'b1, IDX_PTR_LOW);
      op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, a);
      chk({16'h0, memPtr[15:0]}, {16'h0, a[7:0], a[15:8]});
      rdx(1'b1, 1'b1, 1'b1, 16'hFFFF, a);
      cmd(1'b0, IDX_PTR_TOP);
      op(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0001);
      chk({31'h0, memPtr[16]}, 32'h1);
      // word first so the carry happens on a +2 step
      setp(17'h0FFFE);
      chk({31'h0, burst}, 32'h1);
      op(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, a);
      chk({15'h0, memPtr}, 32'h10000);
      op(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, {8'h00, b});
      chk({15'h0, memPtr}, 32'h10001);
      setp(17'h0FFFE);
      rdx(1'b0, 1'b0, 1'b1, 16'h00FF, {8'h00, a[7:0]});
      rdx(1'b0, 1'b0, 1'b1, 16'h00FF, {8'h00, a[15:8]});
      rdx(1'b0, 1'b0, 1'b1, 16'h00FF, {8'h00, b});
      chk({15'h0, memPtr}, 32'h10001);
      bigEndian <= 1'b1;
      cmd(1'b0, IDX_WORD_ONLY);
      op(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0001);
      rdx(1'b0, 1'b0, 1'b1, 16'h0001, 16'h0001);
      setp(17'h00010);
      op(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, a);
      chk({15'h0, memPtr}, 32'h00012);
      cmd(1'b0, IDX_BURST);
      op(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, {c, b});
      chk({15'h0, memPtr}, 32'h00014);
      setp(17'h00010);
      rdx(1'b0, 1'b0, 1'b1, 16'hFFFF, a);
      cmd(1'b1, IDX_PTR_MID);
      op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, {c, 8'h00});
      chk({24'h0, memPtr[15:8]}, {24'h0, c});
      cmd(1'b0, IDX_WORD_ONLY);
      op(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
      setp(17'h00010);
      rdx(1'b0, 1'b0, 1'b1, 16'h00FF, {8'h00, a[15:8]});
      rdx(1'b0, 1'b0, 1'b1, 16'h00FF, {8'h00, a[7:0]});
      chk({15'h0, memPtr}, 32'h00012);
      repeat (4) @(posedge sys_clk);
      test_done();
   end
endmodule
